// ==== verilog/nfc_consts.svh ====
// Purpose: Constants for the NOR flash command host
// Assumes: 50 MHz clock, byte addresses with bit 0 as the x8 byte select
// Notes: Offsets are byte addresses on the host register port
`ifndef NFC_CONSTS_SVH
`define NFC_CONSTS_SVH
`define NFC_ADDR_W 25
`define NFC_CLK_NS 20
`define NFC_T_WP_NS 60
`define NFC_T_ACC_NS 100
`define NFC_WP_CYC ((`NFC_T_WP_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_ACC_CYC ((`NFC_T_ACC_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_U1_X8 25'h0000aaa
`define NFC_U2_X8 25'h0000555
`define NFC_U1_X16 25'h0000555
`define NFC_U2_X16 25'h00002aa
`define NFC_D_UNLK1 16'h00aa
`define NFC_D_UNLK2 16'h0055
`define NFC_D_RESET 16'h00f0
`define NFC_D_CFI 16'h0098
`define NFC_D_AUTOSEL 16'h0090
`define NFC_D_BYPASS 16'h0020
`define NFC_D_BYP_EXIT 16'h0000
`define NFC_D_PROG 16'h00a0
`define NFC_D_BUF 16'h0025
`define NFC_D_CONFIRM 16'h0029
`define NFC_D_ERASE 16'h0080
`define NFC_D_CHIP 16'h0010
`define NFC_D_BLOCK 16'h0030
`define NFC_BIT_TOGGLE 6
`define NFC_BIT_ERROR 5
`define NFC_BIT_ABORT 1
`define NFC_LOCK_RSVD 16'hfff8
`define NFC_LOCK_RESET 16'hffff
`define NFC_REG_CMD 8'h00
`define NFC_REG_ADDR 8'h04
`define NFC_REG_DATA 8'h08
`define NFC_REG_CFG 8'h0c
`define NFC_REG_COUNT 8'h10
`define NFC_REG_LOCK 8'h14
`define NFC_REG_STATUS 8'h18
`define NFC_REG_RDATA 8'h1c
`endif

// ==== verilog/nfc_pkg.sv ====
// Purpose: Types shared by the NOR flash command host
// Assumes: nfc_consts.svh gives the widths
// Notes: Op codes follow the enum order
`include "nfc_consts.svh"
package nfc_pkg;
  typedef logic [`NFC_ADDR_W-1:0] nfc_addr_t;
  typedef enum logic [3:0] {
    OP_RESET1, OP_RESET3, OP_CFI, OP_AUTOSEL, OP_BYPASS, OP_BYP_RESET,
    OP_PROGRAM, OP_BUF_START, OP_BUF_WORD, OP_BUF_CONFIRM, OP_CHIP_ERASE,
    OP_BLOCK_ERASE, OP_BLOCK_ADD, OP_LOCK_PROG, OP_READ
  } nfc_op_e;
  typedef enum logic [1:0] {MD_READ, MD_CFI, MD_AUTOSEL} nfc_mode_e;
  typedef struct packed {
    logic rd;
    logic last;
    nfc_addr_t addr;
    logic [15:0] data;
  } nfc_cycle_s;
  typedef struct packed {
    logic [15:0] dq;
    logic ready;
  } nfc_pins_s;
endpackage

// ==== verilog/nfc_sync.sv ====
// Purpose: Two-stage synchroniser for the flash input pins
// Assumes: Pins are asynchronous to clk_i
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module nfc_sync #(
  parameter int W = 17
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
      begin
        meta_r[i] <= 1'b0;
        sync_o[i] <= 1'b0;
      end
      else if (clk_en_i)
      begin
        meta_r[i] <= async_i[i];
        sync_o[i] <= meta_r[i];
      end
    end
  end
endmodule

// ==== verilog/nfc_engine.sv ====
// Purpose: Runs one asynchronous flash bus cycle, write or read
// Assumes: dq_i is already synchronised, two cycles late
// Notes: In x8 mode the data pin 15 carries the byte select
`timescale 1ns/1ps
`include "nfc_consts.svh"
module nfc_engine (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Request
  input wire logic req_i,
  input wire nfc_pkg::nfc_cycle_s cyc_i,
  input wire logic x16_i,
  input wire logic [15:0] dq_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  // Flash pins
  output logic [`NFC_ADDR_W-2:0] fl_addr_o,
  output logic [15:0] fl_dq_o,
  output logic [15:0] fl_dq_oe_o,
  output logic fl_ce_n_o,
  output logic fl_oe_n_o,
  output logic fl_we_n_o
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} nfc_eng_e;
  // Reads wait two extra cycles for the synchroniser
  localparam logic [7:0] WR_CYC = 8'(`NFC_WP_CYC);
  localparam logic [7:0] RD_CYC = 8'(`NFC_ACC_CYC + 2);
  nfc_eng_e st_r;
  logic [7:0] cnt_r;
  logic rd_r;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= E_IDLE;
      cnt_r <= 8'h00;
      rd_r <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
      fl_addr_o <= '0;
      fl_dq_o <= 16'h0000;
      fl_dq_oe_o <= 16'h0000;
      fl_ce_n_o <= 1'b1;
      fl_oe_n_o <= 1'b1;
      fl_we_n_o <= 1'b1;
    end
    else if (clk_en_i)
    begin
      done_o <= 1'b0;
      case (st_r)
        E_IDLE:
        begin
          if (req_i)
          begin
            rd_r <= cyc_i.rd;
            fl_ce_n_o <= 1'b0;
            fl_addr_o <= x16_i ? cyc_i.addr[`NFC_ADDR_W-2:0]
                               : cyc_i.addr[`NFC_ADDR_W-1:1];
            fl_dq_o <= x16_i ? cyc_i.data : {cyc_i.addr[0], 7'h00, cyc_i.data[7:0]};
            fl_dq_oe_o <= cyc_i.rd ? (x16_i ? 16'h0000 : 16'h8000)
                                   : (x16_i ? 16'hffff : 16'h80ff);
            st_r <= E_SETUP;
          end
        end
        E_SETUP:
        begin
          fl_we_n_o <= rd_r;
          fl_oe_n_o <= !rd_r;
          cnt_r <= rd_r ? RD_CYC : WR_CYC;
          st_r <= E_STROBE;
        end
        E_STROBE:
        begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01)
          begin
            rdata_o <= x16_i ? dq_i : {8'h00, dq_i[7:0]};
            fl_we_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            st_r <= E_HOLD;
          end
        end
        E_HOLD:
        begin
          fl_ce_n_o <= 1'b1;
          fl_dq_oe_o <= 16'h0000;
          done_o <= 1'b1;
          st_r <= E_IDLE;
        end
        default:
          st_r <= E_IDLE;
      endcase
    end
  end
endmodule

// ==== verilog/nfc_host.sv ====
// Purpose: Host controller that issues NOR flash command sequences
// Assumes: Software drives the plain register port; flash pins asynchronous
// Notes: Writes to CMD launch an op; STATUS shows progress and failures
// Notes on behaviour
// R1: Error or abort bit during polling is failure
// R2: Toggle polling also serves blank check
// R3: Lock word bits 15 to 3 read 1
// R4: Lock bit 2 zero selects password mode
// R5: Lock bit 1 zero fixes nonvolatile mode
// R6: Shipped state: nonvolatile mode, nothing protected
// R7: Lock bit 0 zero protects extended block
// R8: Extended block protection readable in auto select
// R9: Never both protection mode bits zero
// R10: Each lock bit programs only once
// R11: Ignore error and abort bits for lock programming
// R12: Reset is F0 once or three cycles
// R13: CFI entered by 98, left by F0
// R14: Auto select is AA, 55, 90
// R15: Unlock bypass is AA, 55, 20
// R16: Program is two unlock cycles, A0, then data
// R17: Bypass program skips the two unlock cycles
// R18: Buffer program: 25, count, then pairs
// R19: Confirm 29 in same block starts programming
// R20: Buffer holds 256 bytes or 512 words
// R21: Upper address bits fixed during buffer load
// R22: Chip erase ends 80, 10; block 30
// R23: After error, reset before anything else
// R24: Only 90, 00 leaves unlock bypass
// R25: Resets ignored while an operation runs
// R26: Mismatched cycle abandons partial sequence
`timescale 1ns/1ps
`include "nfc_consts.svh"
module nfc_host #(
  parameter int BUF_WORDS = 512,
  parameter int BUF_BYTES = 256,
  parameter logic [15:0] LOCK_ENTRY = 16'h0040
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Flash pins
  output logic [`NFC_ADDR_W-2:0] fl_addr_o,
  input wire logic [15:0] fl_dq_i,
  output logic [15:0] fl_dq_o,
  output logic [15:0] fl_dq_oe_o,
  output logic fl_ce_n_o,
  output logic fl_oe_n_o,
  output logic fl_we_n_o,
  output logic fl_byte_n_o,
  input wire logic fl_ready_busy_n_i
);
  // Depths above 512 are rejected, though the ten-bit COUNT could describe more
  if (BUF_WORDS < 1 || BUF_WORDS > 512 || BUF_BYTES < 1 || BUF_BYTES > 512)
  begin : g_bad_depth
    $error("buffer depth out of range");
  end

  typedef enum logic [2:0] {Q_IDLE, Q_ISSUE, Q_WAIT, Q_POLL, Q_PWAIT, Q_FINISH} nfc_seq_e;

  // Registers written by software
  nfc_pkg::nfc_op_e op_r;
  nfc_pkg::nfc_addr_t addr_r;
  logic [15:0] data_r;
  logic x16_r;
  logic more_blocks_r;
  logic [9:0] count_r;
  logic [15:0] lock_r;
  logic launch_r;
  // Sequencer state
  nfc_seq_e st_r;
  logic [2:0] step_r;
  logic [1:0] pstep_r;
  nfc_pkg::nfc_cycle_s cyc_r;
  logic eng_req_r;
  logic [15:0] prev_r;
  logic [15:0] rdata_r;
  logic fail_err_r;
  logic fail_abt_r;
  // Status
  nfc_pkg::nfc_mode_e mode_r;
  logic bypass_r;
  logic error_r;
  logic abort_r;
  logic refused_r;
  logic buf_open_r;
  logic [9:0] left_r;
  nfc_pkg::nfc_addr_t blk_r;
  // Engine link
  logic eng_done;
  logic [15:0] eng_rdata;
  nfc_pkg::nfc_pins_s pins_sync;

  nfc_sync #(
    .W(17)
  ) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .async_i({fl_dq_i, fl_ready_busy_n_i}),
    .sync_o(pins_sync)
  );

  nfc_engine u_eng (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .req_i(eng_req_r),
    .cyc_i(cyc_r),
    .x16_i(x16_r),
    .dq_i(pins_sync.dq),
    .done_o(eng_done),
    .rdata_o(eng_rdata),
    .fl_addr_o(fl_addr_o),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o),
    .fl_ce_n_o(fl_ce_n_o),
    .fl_oe_n_o(fl_oe_n_o),
    .fl_we_n_o(fl_we_n_o)
  );

  function automatic nfc_pkg::nfc_cycle_s mk(input logic rd, input logic last,
      input nfc_pkg::nfc_addr_t a, input logic [15:0] d);
    nfc_pkg::nfc_cycle_s c;
    c.rd = rd;
    c.last = last;
    c.addr = a;
    c.data = d;
    return c;
  endfunction

  // Address and data of one cycle of an op's command sequence
  function automatic nfc_pkg::nfc_cycle_s seq_cycle(input nfc_pkg::nfc_op_e op,
      input logic [2:0] step, input logic x16, input logic byp,
      input nfc_pkg::nfc_addr_t a, input logic [15:0] d,
      input nfc_pkg::nfc_addr_t blk, input logic [9:0] n);
    nfc_pkg::nfc_addr_t u1;
    nfc_pkg::nfc_addr_t u2;
    nfc_pkg::nfc_addr_t z;
    nfc_pkg::nfc_cycle_s c;
    u1 = x16 ? `NFC_U1_X16 : `NFC_U1_X8;
    u2 = x16 ? `NFC_U2_X16 : `NFC_U2_X8;
    z = '0;
    c = mk(1'b0, 1'b1, z, `NFC_D_RESET);
    if (step == 3'd0 || step == 3'd3)
      c = mk(1'b0, 1'b0, u1, `NFC_D_UNLK1);
    else if (step == 3'd1 || step == 3'd4)
      c = mk(1'b0, 1'b0, u2, `NFC_D_UNLK2);
    case (op)
      nfc_pkg::OP_RESET1: c = mk(1'b0, 1'b1, z, `NFC_D_RESET); // R12
      nfc_pkg::OP_RESET3: if (step == 3'd2) c = mk(1'b0, 1'b1, u1, `NFC_D_RESET); // R12
      nfc_pkg::OP_CFI: c = mk(1'b0, 1'b1, u1, `NFC_D_CFI); // R13
      nfc_pkg::OP_AUTOSEL: if (step == 3'd2) c = mk(1'b0, 1'b1, u1, `NFC_D_AUTOSEL); // R14
      nfc_pkg::OP_BYPASS: if (step == 3'd2) c = mk(1'b0, 1'b1, u1, `NFC_D_BYPASS); // R15
      nfc_pkg::OP_BYP_RESET: // R24
        c = (step == 3'd0) ? mk(1'b0, 1'b0, z, `NFC_D_AUTOSEL)
                           : mk(1'b0, 1'b1, z, `NFC_D_BYP_EXIT);
      nfc_pkg::OP_PROGRAM:
        if (byp) // R17
          c = (step == 3'd0) ? mk(1'b0, 1'b0, z, `NFC_D_PROG) : mk(1'b0, 1'b1, a, d);
        else if (step == 3'd2) // R16
          c = mk(1'b0, 1'b0, u1, `NFC_D_PROG);
        else if (step == 3'd3)
          c = mk(1'b0, 1'b1, a, d);
      nfc_pkg::OP_BUF_START: // R18
        if (step == (byp ? 3'd0 : 3'd2))
          c = mk(1'b0, 1'b0, a, `NFC_D_BUF);
        else if (step == (byp ? 3'd1 : 3'd3))
          c = mk(1'b0, 1'b1, a, {6'h00, n});
      nfc_pkg::OP_BUF_WORD: // R21
        c = mk(1'b0, 1'b1, x16 ? {blk[`NFC_ADDR_W-1:9], a[8:0]}
                               : {blk[`NFC_ADDR_W-1:8], a[7:0]}, d);
      nfc_pkg::OP_BUF_CONFIRM: c = mk(1'b0, 1'b1, blk, `NFC_D_CONFIRM); // R19
      nfc_pkg::OP_CHIP_ERASE, nfc_pkg::OP_BLOCK_ERASE: // R22
        if (byp)
          c = (step == 3'd0) ? mk(1'b0, 1'b0, z, `NFC_D_ERASE)
            : mk(1'b0, 1'b1, (op == nfc_pkg::OP_BLOCK_ERASE) ? a : z,
                 (op == nfc_pkg::OP_BLOCK_ERASE) ? `NFC_D_BLOCK : `NFC_D_CHIP);
        else if (step == 3'd2)
          c = mk(1'b0, 1'b0, u1, `NFC_D_ERASE);
        else if (step == 3'd5)
          c = mk(1'b0, 1'b1, (op == nfc_pkg::OP_BLOCK_ERASE) ? a : u1,
                 (op == nfc_pkg::OP_BLOCK_ERASE) ? `NFC_D_BLOCK : `NFC_D_CHIP);
      nfc_pkg::OP_BLOCK_ADD: c = mk(1'b0, 1'b1, a, `NFC_D_BLOCK); // R22
      nfc_pkg::OP_LOCK_PROG:
        if (step == 3'd2)
          c = mk(1'b0, 1'b0, u1, LOCK_ENTRY);
        else if (step == 3'd3)
          c = mk(1'b0, 1'b0, z, `NFC_D_PROG);
        else if (step == 3'd4)
          c = mk(1'b0, 1'b1, z, d | `NFC_LOCK_RSVD); // R3
      nfc_pkg::OP_READ: c = mk(1'b1, 1'b1, a, 16'h0000);
      default: c = mk(1'b0, 1'b1, z, `NFC_D_RESET);
    endcase
    return c;
  endfunction

  // Whether the op is legal in the present state
  function automatic logic op_ok(input nfc_pkg::nfc_op_e op);
    logic ok;
    logic [15:0] nl;
    nl = data_r | `NFC_LOCK_RSVD;
    ok = 1'b1;
    if (abort_r && op != nfc_pkg::OP_RESET3)
      ok = 1'b0; // R12
    else if (error_r && op != nfc_pkg::OP_RESET1 && op != nfc_pkg::OP_RESET3)
      ok = 1'b0; // R23
    case (op)
      nfc_pkg::OP_CFI: if (bypass_r || mode_r == nfc_pkg::MD_CFI) ok = 1'b0;
      nfc_pkg::OP_AUTOSEL, nfc_pkg::OP_BYPASS, nfc_pkg::OP_LOCK_PROG:
        if (bypass_r) ok = 1'b0;
      nfc_pkg::OP_BYP_RESET: if (!bypass_r) ok = 1'b0; // R24
      nfc_pkg::OP_BUF_START: // R20
        if (buf_open_r || {22'h0, count_r} >= (x16_r ? BUF_WORDS : BUF_BYTES))
          ok = 1'b0;
      nfc_pkg::OP_BUF_WORD: if (!buf_open_r || left_r == 10'h000) ok = 1'b0;
      nfc_pkg::OP_BUF_CONFIRM: if (!buf_open_r || left_r != 10'h000) ok = 1'b0; // R19
      default: ok = ok;
    endcase
    if (op == nfc_pkg::OP_LOCK_PROG)
    begin
      if (!nl[1] && !nl[2])
        ok = 1'b0; // R9
      if ((nl[1] == 1'b0 && lock_r[2] == 1'b0) || (nl[2] == 1'b0 && lock_r[1] == 1'b0))
        ok = 1'b0; // R9
      if (|(nl & ~lock_r))
        ok = 1'b0; // R10
    end
    if (buf_open_r && op != nfc_pkg::OP_BUF_WORD && op != nfc_pkg::OP_BUF_CONFIRM)
      ok = 1'b0;
    return ok;
  endfunction

  function automatic logic op_polls(input nfc_pkg::nfc_op_e op, input logic more);
    case (op)
      nfc_pkg::OP_PROGRAM, nfc_pkg::OP_BUF_CONFIRM, nfc_pkg::OP_CHIP_ERASE,
      nfc_pkg::OP_LOCK_PROG: op_polls = 1'b1;
      nfc_pkg::OP_BLOCK_ERASE, nfc_pkg::OP_BLOCK_ADD: op_polls = !more;
      default: op_polls = 1'b0;
    endcase
  endfunction

  // Register writes; a launch while busy is dropped so resets cannot cut in
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      op_r <= nfc_pkg::OP_RESET1;
      addr_r <= '0;
      data_r <= 16'h0000;
      x16_r <= 1'b1;
      more_blocks_r <= 1'b0;
      count_r <= 10'h000;
      lock_r <= `NFC_LOCK_RESET; // R4 R5 R6 R7
      launch_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      launch_r <= 1'b0;
      // Shadow follows a finished lock program so later refusals see it
      if (st_r == Q_FINISH && op_r == nfc_pkg::OP_LOCK_PROG)
        lock_r <= lock_r & (data_r | `NFC_LOCK_RSVD); // R10
      if (reg_wr_i)
      begin
        case (reg_addr_i)
          `NFC_REG_CMD:
            if (st_r == Q_IDLE && !launch_r)
            begin
              op_r <= nfc_pkg::nfc_op_e'(reg_wdata_i[3:0]);
              launch_r <= 1'b1; // R25
            end
          `NFC_REG_ADDR: addr_r <= reg_wdata_i[`NFC_ADDR_W-1:0];
          `NFC_REG_DATA: data_r <= reg_wdata_i[15:0];
          `NFC_REG_CFG:
          begin
            x16_r <= reg_wdata_i[0];
            more_blocks_r <= reg_wdata_i[1];
          end
          `NFC_REG_COUNT: count_r <= reg_wdata_i[9:0];
          `NFC_REG_LOCK: lock_r <= reg_wdata_i[15:0] | `NFC_LOCK_RSVD; // R3
          default: ;
        endcase
      end
    end
  end

  // Register reads, answered one cycle later
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (clk_en_i)
    begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          `NFC_REG_CMD: reg_rdata_o <= {28'h0, op_r};
          `NFC_REG_ADDR: reg_rdata_o <= {7'h00, addr_r};
          `NFC_REG_DATA: reg_rdata_o <= {16'h0000, data_r};
          `NFC_REG_CFG: reg_rdata_o <= {30'h0, more_blocks_r, x16_r};
          `NFC_REG_COUNT: reg_rdata_o <= {22'h0, count_r};
          `NFC_REG_LOCK: reg_rdata_o <= {16'h0000, lock_r}; // R3
          `NFC_REG_STATUS:
            reg_rdata_o <= {13'h0000, left_r, pins_sync.ready, buf_open_r, bypass_r,
                            mode_r, refused_r, abort_r, error_r, (st_r != Q_IDLE)};
          `NFC_REG_RDATA: reg_rdata_o <= {16'h0000, rdata_r};
          default: reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      fl_byte_n_o <= 1'b1;
    else if (clk_en_i)
      fl_byte_n_o <= x16_r;
  end

  // Sequencer
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= Q_IDLE;
      step_r <= 3'd0;
      pstep_r <= 2'd0;
      cyc_r <= '0;
      eng_req_r <= 1'b0;
      prev_r <= 16'h0000;
      rdata_r <= 16'h0000;
      fail_err_r <= 1'b0;
      fail_abt_r <= 1'b0;
      refused_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      eng_req_r <= 1'b0;
      case (st_r)
        Q_IDLE:
          if (launch_r)
          begin
            step_r <= 3'd0;
            fail_err_r <= 1'b0;
            fail_abt_r <= 1'b0;
            refused_r <= !op_ok(op_r); // R26
            st_r <= op_ok(op_r) ? Q_ISSUE : Q_IDLE;
          end
        Q_ISSUE:
        begin
          cyc_r <= seq_cycle(op_r, step_r, x16_r, bypass_r, addr_r, data_r, blk_r, count_r);
          eng_req_r <= 1'b1;
          st_r <= Q_WAIT;
        end
        Q_WAIT:
          if (eng_done)
          begin
            if (cyc_r.rd)
              rdata_r <= eng_rdata; // R8
            step_r <= step_r + 3'd1;
            pstep_r <= 2'd0;
            if (!cyc_r.last)
              st_r <= Q_ISSUE;
            else
              st_r <= op_polls(op_r, more_blocks_r) ? Q_POLL : Q_FINISH;
          end
        Q_POLL:
        begin
          cyc_r <= mk(1'b1, 1'b1, cyc_r.addr, 16'h0000);
          eng_req_r <= 1'b1;
          st_r <= Q_PWAIT;
        end
        Q_PWAIT:
          if (eng_done)
          begin
            prev_r <= eng_rdata;
            pstep_r <= pstep_r + 2'd1;
            st_r <= Q_POLL;
            if (pstep_r[0])
            begin
              // Toggle polling, which also covers blank check
              if (prev_r[`NFC_BIT_TOGGLE] == eng_rdata[`NFC_BIT_TOGGLE]) // R2
                st_r <= Q_FINISH;
              else if (pstep_r == 2'd3)
                st_r <= Q_FINISH; // R1
              else if (op_r != nfc_pkg::OP_LOCK_PROG && // R11
                       (eng_rdata[`NFC_BIT_ERROR] || eng_rdata[`NFC_BIT_ABORT]))
              begin
                fail_err_r <= eng_rdata[`NFC_BIT_ERROR]; // R1
                fail_abt_r <= eng_rdata[`NFC_BIT_ABORT] && !eng_rdata[`NFC_BIT_ERROR];
              end
              else
                pstep_r <= 2'd0;
              if (prev_r[`NFC_BIT_TOGGLE] == eng_rdata[`NFC_BIT_TOGGLE] && pstep_r == 2'd3)
              begin
                fail_err_r <= 1'b0;
                fail_abt_r <= 1'b0;
              end
            end
          end
        Q_FINISH:
          st_r <= Q_IDLE;
        default:
          st_r <= Q_IDLE;
      endcase
    end
  end

  // Device mode and failure tracking, updated as an op completes
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mode_r <= nfc_pkg::MD_READ;
      bypass_r <= 1'b0;
      error_r <= 1'b0;
      abort_r <= 1'b0;
      buf_open_r <= 1'b0;
      left_r <= 10'h000;
      blk_r <= '0;
    end
    else if (clk_en_i && st_r == Q_FINISH)
    begin
      case (op_r)
        nfc_pkg::OP_RESET1:
        begin
          mode_r <= nfc_pkg::MD_READ;
          error_r <= 1'b0; // R23
        end
        nfc_pkg::OP_RESET3:
        begin
          mode_r <= nfc_pkg::MD_READ;
          error_r <= 1'b0;
          abort_r <= 1'b0; // R12
        end
        nfc_pkg::OP_CFI: mode_r <= nfc_pkg::MD_CFI; // R13
        nfc_pkg::OP_AUTOSEL: mode_r <= nfc_pkg::MD_AUTOSEL; // R14
        nfc_pkg::OP_BYPASS: bypass_r <= 1'b1; // R15
        nfc_pkg::OP_BYP_RESET: bypass_r <= 1'b0; // R24
        nfc_pkg::OP_BUF_START:
        begin
          buf_open_r <= 1'b1;
          left_r <= count_r + 10'h001; // R20
          blk_r <= addr_r; // R18
        end
        nfc_pkg::OP_BUF_WORD: left_r <= left_r - 10'h001;
        nfc_pkg::OP_BUF_CONFIRM: buf_open_r <= 1'b0;
        default: mode_r <= mode_r;
      endcase
      if (fail_err_r)
        error_r <= 1'b1; // R1
      if (fail_abt_r)
        abort_r <= 1'b1; // R1
    end
  end
endmodule

// ==== verification/nfc_host_props.sv ====
// Purpose: Port checker for the flash command host
// Assumes: clk_en_i held high
// Notes: Bound to nfc_host below
`timescale 1ns/1ps
module nfc_host_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Watched ports
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [23:0] fl_addr_o,
  input wire logic [15:0] fl_dq_oe_o,
  input wire logic fl_ce_n_o,
  input wire logic fl_oe_n_o,
  input wire logic fl_we_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  a_strobe_excl: assert property (fl_we_n_o || fl_oe_n_o)
    else $error("write and read strobes together");
  a_we_width: assert property ($fell(fl_we_n_o) |-> !fl_we_n_o [*3] ##1 fl_we_n_o)
    else $error("write pulse not three cycles");
  a_oe_width: assert property ($fell(fl_oe_n_o) |-> !fl_oe_n_o [*7] ##1 fl_oe_n_o)
    else $error("read pulse not seven cycles");
  a_ce_cover: assert property (!fl_we_n_o || !fl_oe_n_o |-> !fl_ce_n_o)
    else $error("strobe without chip select");
  a_read_float: assert property (!fl_oe_n_o |-> fl_dq_oe_o[14:0] == 15'h0)
    else $error("host drives data during read");
  a_write_drive: assert property (!fl_we_n_o |-> fl_dq_oe_o[7:0] == 8'hff)
    else $error("data not driven during write");
  a_addr_hold: assert property (!fl_ce_n_o && !$past(fl_ce_n_o) |-> $stable(fl_addr_o))
    else $error("address moved inside a cycle");
  c_write: cover property ($rose(fl_we_n_o));
  c_read: cover property ($rose(fl_oe_n_o));
  c_rdata: cover property ($past(reg_rd_i) && reg_rdata_o != 32'h0);
endmodule
bind nfc_host nfc_host_props i_props (.clk_i, .sys_rst_i, .reg_rd_i, .reg_rdata_o,
  .fl_addr_o, .fl_dq_oe_o, .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o);

// ==== verification/nfc_flash_model.sv ====
// Purpose: Behavioural flash device for the host bench
// Assumes: Commands decoded from the low data byte
// Notes: Busy lasts three status reads; err_i makes it fail
`timescale 1ns/1ps
module nfc_flash_model (
  // Bus from host
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [15:0] dq_i,
  // Fault injection
  input wire logic err_i,
  // Answers
  output logic [15:0] dq_o,
  output logic rb_n_o
);
  logic [7:0] p1_r = 8'h00;
  logic [7:0] p2_r = 8'h00;
  logic [15:0] lock_r = 16'hffff;
  logic [15:0] last_r = 16'h0000;
  logic [15:0] v;
  logic [2:0] bsy_r = 3'h0;
  logic tg_r = 1'b0;
  logic abt_r = 1'b0;
  logic bad;
  // A failed buffer confirm reports abort, anything else reports error
  assign bad = err_i && bsy_r != 3'h0;
  assign v = {9'h0, tg_r, bad && !abt_r, 3'h0, bad && abt_r, 1'b0};
  // Released bus shows the inverse so stale data cannot pass
  assign dq_o = (!ce_n_i && !oe_n_i) ? v : ~last_r;
  assign rb_n_o = (bsy_r == 3'h0);
  always @(posedge we_n_i)
  begin
    if (p1_r == 8'ha0 && p2_r == 8'h40)
    begin
      if ((lock_r[2:1] & dq_i[2:1]) != 2'h0)
      begin
        lock_r <= lock_r & dq_i;
        bsy_r <= 3'h3;
      end
    end
    else if (p1_r == 8'ha0 || dq_i[7:0] == 8'h10 || dq_i[7:0] == 8'h30)
      bsy_r <= 3'h3;
    else if (dq_i[7:0] == 8'h29)
      bsy_r <= 3'h3;
    else if (dq_i[7:0] == 8'hf0 && err_i)
      bsy_r <= 3'h0;
    p2_r <= p1_r;
    p1_r <= dq_i[7:0];
    abt_r <= dq_i[7:0] == 8'h29;
  end
  always @(posedge oe_n_i)
  begin
    last_r <= v;
    if (bsy_r != 3'h0)
      tg_r <= ~tg_r;
    if (bsy_r != 3'h0 && !err_i)
      bsy_r <= bsy_r - 3'h1;
  end
endmodule

// ==== verification/nfc_host_test.sv ====
// Purpose: Register level bench for the flash command host
// Assumes: x16 bus until the closing block erase and read ops, which run x8; flash model as far side
// Notes: Status expectations are {bypass, mode, refused, abort, error}
`timescale 1ns/1ps
module nfc_host_test;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic err = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic [23:0] fl_addr_o;
  logic [15:0] fl_dq_i, fl_dq_o, fl_dq_oe_o, mdq;
  logic fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_byte_n_o, rbn;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  initial forever #10 clk_i = ~clk_i;
  assign fl_dq_i = (fl_dq_oe_o & fl_dq_o) | (~fl_dq_oe_o & mdq);
  nfc_host i_dut (.clk_i, .sys_rst_i, .clk_en_i(1'b1), .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fl_addr_o, .fl_dq_i, .fl_dq_o, .fl_dq_oe_o,
    .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o, .fl_byte_n_o, .fl_ready_busy_n_i(rbn));
  nfc_flash_model i_flash (.ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o),
    .dq_i(fl_dq_i), .err_i(err), .dq_o(mdq), .rb_n_o(rbn));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input [31:0] e, input [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input [7:0] a, output [31:0] v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
    @(posedge clk_i);
  endtask
  // Launch, wait for idle, compare status; refused bit only when expected
  task automatic op(input [3:0] c, input [5:0] e);
    logic [31:0] s;
    s = 32'h1;
    wr(8'h00, {28'h0, c});
    @(posedge clk_i);
    for (int n = 0; n < 3000 && s[0] !== 1'b0; n++)
      rd(8'h18, s);
    chk("status", {25'h0, e, 1'b0}, {25'h0, s[6:0] & {3'h7, e[2], 3'h7}});
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    logic [31:0] v;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h14, v);
    chk("lock", 32'h0000ffff, v);
    rd(8'h18, v);
    chk("idle", 32'h0, v & 32'h7f);
    rd(8'h40, v);
    chk("unmapped", 32'h0, v);
    op(4'd6, 6'h00);
    op(4'd2, 6'h08);
    op(4'd2, 6'h0c);
    op(4'd0, 6'h00);
    op(4'd3, 6'h10);
    op(4'd1, 6'h00);
    op(4'd4, 6'h20);
    op(4'd0, 6'h20);
    op(4'd3, 6'h24);
    op(4'd6, 6'h20);
    op(4'd5, 6'h00);
    op(4'd10, 6'h00);
    op(4'd11, 6'h00);
    wr(8'h10, 32'd512);
    op(4'd7, 6'h04);
    wr(8'h10, 32'd511);
    op(4'd7, 6'h00);
    rd(8'h18, v);
    chk("left", 32'd512, {22'h0, v[18:9]});
    for (int i = 0; i < 512; i++)
    begin
      wr(8'h04, i * 2);
      op(4'd8, 6'h00);
    end
    err <= 1'b1;
    op(4'd9, 6'h02);
    rd(8'h18, v);
    chk("closed", 32'h0, {21'h0, v[18:9], v[7]});
    op(4'd0, 6'h06);
    op(4'd1, 6'h00);
    op(4'd6, 6'h01);
    op(4'd3, 6'h05);
    op(4'd0, 6'h00);
    err <= 1'b0;
    wr(8'h08, 32'hfffd);
    op(4'd13, 6'h00);
    wr(8'h08, 32'hfffb);
    op(4'd13, 6'h04);
    wr(8'h08, 32'hffff);
    op(4'd13, 6'h04);
    rd(8'h14, v);
    chk("lock", 32'h0000fffd, v);
    wr(8'h0c, 32'h2);
    op(4'd11, 6'h00);
    op(4'd12, 6'h00);
    op(4'd14, 6'h00);
    rd(8'h1c, v);
    chk("rdata", 32'h0, v & 32'hffbf);
    chk("byte", 32'h0, {31'h0, fl_byte_n_o});
    give_verdict();
  end
endmodule
